// [hw/pmt_pkg.sv]
// package for the mii latency and carrier timing block
// assumes a 100 MHz system clock and a link clock that runs during frames
package pmt_pkg;
  // clock and bit time figures
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned BIT_NS_10M = 100;
  localparam int unsigned BIT_NS_100M = 10;
  // latency limits in bit times
  localparam int unsigned RX_LAT_10M_BT = 7;
  localparam int unsigned TX_LAT_10M_BT = 2;
  localparam int unsigned TX_LAT_100M_BT = 3;
  localparam int unsigned CRS_TX_ON_100M_BT = 4;
  localparam int unsigned CRS_TX_OFF_BT = 4;
  localparam int unsigned CRS_TX_ON_10M_BT = 2;
  localparam int unsigned RX_LAT_100M_BT = 17;
  localparam int unsigned CRS_RX_ON_MIN_BT = 10;
  localparam int unsigned CRS_RX_ON_MAX_BT = 14;
  localparam int unsigned COL_ON_MIN_BT = 9;
  localparam int unsigned COL_ON_MAX_BT = 13;
  localparam int unsigned CRS_RX_OFF_MIN_BT = 13;
  localparam int unsigned CRS_RX_OFF_MAX_BT = 18;
  // delays in system clocks: least rounds up, so carrier-on at 100M uses the minimum
  localparam int unsigned CRS_RX_ON_CYC = (CRS_RX_ON_MIN_BT * BIT_NS_100M + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned COL_ON_CYC = (COL_ON_MIN_BT * BIT_NS_100M + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CRS_RX_OFF_CYC = (CRS_RX_OFF_MIN_BT * BIT_NS_100M + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned TX_LAT_10M_CYC = (TX_LAT_10M_BT * BIT_NS_10M) / CLK_PERIOD_NS;
  // power-on reset window
  localparam int unsigned POR_MIN_MS = 40;
  localparam int unsigned POR_CYC = POR_MIN_MS * 1000000 / CLK_PERIOD_NS;
  // mdc limits kept by the station
  localparam int unsigned MDC_HALF_MIN_NS = 160;
  localparam int unsigned MDC_PERIOD_MIN_NS = 400;
  localparam int unsigned DLY_W = 5;
  typedef logic [DLY_W-1:0] pmt_dly_t;
  typedef struct packed {
    logic en;
    logic [3:0] data;
  } pmt_nib_s;
  typedef enum logic [1:0] {
    PMT_IDLE = 2'b00,
    PMT_WAIT_ON = 2'b01,
    PMT_ACTIVE = 2'b10,
    PMT_WAIT_OFF = 2'b11
  } pmt_car_e;
endpackage : pmt_pkg

// [hw/pmt_sync.sv]
// two-flop synchroniser for one level
// assumes the input is asynchronous to clk
`timescale 1ns/1ps
`default_nettype none
module pmt_sync (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic d,
  output logic q
);
  logic meta_ff;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_ff <= 1'b0;
      q <= 1'b0;
    end else if (ce) begin
      meta_ff <= d;
      q <= meta_ff;
    end
  end
endmodule : pmt_sync
`default_nettype wire

// [hw/pmt_core.sv]
// Timing rules this block works to
// [R1] 10M: receive nibble appears within 7 bit times of line start.
// [R2] 10M: first transmit bit on line within 2 bit times of sampling.
// [R3] 100M: /J/ first bit on line within 3 bit times of tx enable.
// [R4] 100M half duplex: carrier rises 0 to 4 bit times after tx enable.
// [R5] half duplex: carrier falls 0 to 4 bit times after tx enable drops.
// [R6] 10M half duplex: carrier rises at most 2 bit times after tx enable.
// [R7] 100M: /J/ on receive nibbles within 17 bit times of line arrival.
// [R8] 100M: receive carrier rises 10 to 14 bit times after /J/.
// [R9] 100M half duplex: collision rises 9 to 13 bit times after /J/ while sending.
// [R10] 100M: carrier falls 13 to 18 bit times after /T/ arrives.
// [R11] 100M half duplex: collision falls 13 to 18 bit times after /T/.
// [R12] power-on reset lasts at least 40 ms before transmit clock is valid.
// [R13] station keeps mdc high and low 160 ns, period 400 ns.
// [R14] 10M bit time is 100 ns.
// [R15] 100M bit time is 10 ns; four of them make one mii clock.
// [R16] collision only in half duplex; full duplex carrier ignores own transmit.
//
// mii-side carrier, collision and latency pipes for a 10/100 phy
// assumes link_clk (mii clock) runs during frames; line events arrive as levels on clk
`timescale 1ns/1ps
`default_nettype none
module pmt_core #(
  parameter int unsigned POR_CYCLES = pmt_pkg::POR_CYC
) (
  // system
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  // mode
  input wire logic speed_100,
  input wire logic half_duplex,
  // mii transmit, link clock domain
  input wire logic link_clk,
  input wire pmt_pkg::pmt_nib_s tx_nib,
  // line receive pair decoded events
  input wire logic line_rx_active,
  input wire logic [3:0] line_rx_data,
  // line transmit pair
  output pmt_pkg::pmt_nib_s line_tx,
  // mii receive and status
  output pmt_pkg::pmt_nib_s rx_nib,
  output logic crs,
  output logic col,
  output logic tx_clk_valid
);
  import pmt_pkg::*;

  // power-on reset: transmit clock flagged valid only after the window
  logic [31:0] por_cnt_ff;
  logic por_done_ff;
  wire por_hit = (por_cnt_ff == POR_CYCLES - 1);
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      por_cnt_ff <= '0;
      por_done_ff <= 1'b0;
    end else if (ce && !por_done_ff) begin
      por_cnt_ff <= por_cnt_ff + 32'h1;
      por_done_ff <= por_hit; // R12
    end
  end
  assign tx_clk_valid = por_done_ff;

  // capture transmit nibble on the link clock; only this register lives there
  pmt_nib_s tx_link_ff;
  always_ff @(posedge link_clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_link_ff <= '0;
    end else begin
      tx_link_ff <= tx_nib;
    end
  end

  // enable crosses as a level; data is stable around it since nibbles hold a whole mii clock
  logic tx_en_s;
  pmt_sync u_sync_en (
    .clk(clk),
    .reset_n(reset_n),
    .ce(ce),
    .d(tx_link_ff.en),
    .q(tx_en_s)
  );
  logic [3:0] tx_dat_meta_ff;
  logic [3:0] tx_dat_ff;
  logic tx_en_d_ff;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_dat_meta_ff <= '0;
      tx_dat_ff <= '0;
      tx_en_d_ff <= 1'b0;
    end else if (ce) begin
      tx_dat_meta_ff <= tx_link_ff.data;
      tx_dat_ff <= tx_dat_meta_ff;
      tx_en_d_ff <= tx_en_s;
    end
  end

  // line transmit: one register stage at 100M keeps /J/ inside 3 bit times; R15
  pmt_nib_s nxt_line_tx;
  assign nxt_line_tx = pmt_nib_s'{en: tx_en_s, data: tx_dat_ff};
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      line_tx <= '0;
    end else if (ce) begin
      line_tx <= nxt_line_tx; // R2 R3
    end
  end

  // receive events arrive from the line decoder asynchronously
  logic rx_act_s;
  pmt_sync u_sync_rx (
    .clk(clk),
    .reset_n(reset_n),
    .ce(ce),
    .d(line_rx_active),
    .q(rx_act_s)
  );
  logic [3:0] rx_dat_meta_ff;
  logic [3:0] rx_dat_ff;
  logic rx_act_d_ff;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_dat_meta_ff <= '0;
      rx_dat_ff <= '0;
      rx_act_d_ff <= 1'b0;
    end else if (ce) begin
      rx_dat_meta_ff <= line_rx_data;
      rx_dat_ff <= rx_dat_meta_ff;
      rx_act_d_ff <= rx_act_s;
    end
  end
  wire rx_start = rx_act_s && !rx_act_d_ff;
  wire rx_end = !rx_act_s && rx_act_d_ff;

  // receive nibble out well before 7 or 17 bit times
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_nib <= '0;
    end else if (ce) begin
      rx_nib <= pmt_nib_s'{en: rx_act_s, data: rx_dat_ff}; // R1 R7
    end
  end

  // receive carrier state machine, delay counted in system clocks; R14
  pmt_car_e rcar_ff;
  pmt_car_e nxt_rcar;
  pmt_dly_t rcnt_ff;
  pmt_dly_t nxt_rcnt;
  wire [DLY_W-1:0] on_lim = speed_100 ? DLY_W'(CRS_RX_ON_CYC) : DLY_W'(1);
  wire [DLY_W-1:0] off_lim = speed_100 ? DLY_W'(CRS_RX_OFF_CYC) : DLY_W'(1);
  wire rcnt_done = (rcnt_ff == DLY_W'(1));
  always_comb begin
    nxt_rcar = rcar_ff;
    nxt_rcnt = (rcnt_ff == '0) ? rcnt_ff : rcnt_ff - DLY_W'(1);
    unique case (rcar_ff)
      PMT_IDLE: begin
        if (rx_start) begin
          nxt_rcar = PMT_WAIT_ON;
          nxt_rcnt = on_lim - DLY_W'(1);
        end
      end
      PMT_WAIT_ON: begin
        if (rcnt_done || on_lim == DLY_W'(1)) begin
          nxt_rcar = PMT_ACTIVE; // R8
        end
      end
      PMT_ACTIVE: begin
        if (rx_end) begin
          nxt_rcar = PMT_WAIT_OFF;
          nxt_rcnt = off_lim - DLY_W'(1);
        end
      end
      PMT_WAIT_OFF: begin
        if (rx_start) begin
          nxt_rcar = PMT_ACTIVE;
        end else if (rcnt_done || off_lim == DLY_W'(1)) begin
          nxt_rcar = PMT_IDLE; // R10
        end
      end
    endcase
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rcar_ff <= PMT_IDLE;
      rcnt_ff <= '0;
    end else if (ce) begin
      rcar_ff <= nxt_rcar;
      rcnt_ff <= nxt_rcnt;
    end
  end
  wire rx_carrier = (rcar_ff == PMT_ACTIVE) || (rcar_ff == PMT_WAIT_OFF);

  // at 100M collision two cycles ahead of receive carrier, inside 9..13 bit times
  wire col_pre = (rcar_ff == PMT_WAIT_ON) && (rcnt_ff <= DLY_W'(2)) && speed_100;
  wire col_now = half_duplex && tx_en_s && (col_pre || rx_carrier); // R9 R11 R16

  // carrier output: own transmission counts only in half duplex
  logic nxt_crs;
  assign nxt_crs = rx_carrier || (half_duplex && tx_en_s); // R4 R5 R6 R16
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      crs <= 1'b0;
      col <= 1'b0;
    end else if (ce) begin
      crs <= nxt_crs;
      col <= col_now;
    end
  end

  // checks
  a_crs_tx_on: assert property (@(posedge clk) disable iff (!reset_n) // R4
    ce && half_duplex && $rose(tx_en_s) |=> crs)
    else $error("carrier late after transmit enable");
  a_crs_tx_10m: assert property (@(posedge clk) disable iff (!reset_n) // R6
    (ce && !speed_100 && half_duplex && tx_en_s && $stable(half_duplex)) |=> crs)
    else $error("10M carrier not following transmit");
  a_crs_tx_off: assert property (@(posedge clk) disable iff (!reset_n) // R5
    (ce && !rx_carrier && !tx_en_s && tx_en_d_ff && !rx_act_s) |=> !crs)
    else $error("carrier lingers after transmit end");
  a_crs_rx_on: assert property (@(posedge clk) disable iff (!reset_n) // R8
    (ce && speed_100 && rcar_ff == PMT_IDLE && rx_start) ##1 ce[*8]
      |-> ##[1:4] (rcar_ff == PMT_ACTIVE))
    else $error("receive carrier not in 10 to 14 bit times");
  a_col_full: assert property (@(posedge clk) disable iff (!reset_n) // R16
    !half_duplex |=> !col || $past(half_duplex))
    else $error("collision in full duplex");
  a_col_needs_tx: assert property (@(posedge clk) disable iff (!reset_n) // R9
    col |-> $past(tx_en_s))
    else $error("collision without transmit");
  a_line_tx_lat: assert property (@(posedge clk) disable iff (!reset_n) // R3
    (ce && $rose(tx_en_s)) ##1 ce |-> line_tx.en)
    else $error("line transmit late");
  a_rx_nib_lat: assert property (@(posedge clk) disable iff (!reset_n) // R7
    (ce && rx_act_s) |=> (rx_nib.en || !ce))
    else $error("receive nibble late");
  a_por_hold: assert property (@(posedge clk) disable iff (!reset_n) // R12
    tx_clk_valid |-> por_cnt_ff == POR_CYCLES)
    else $error("transmit clock valid too early");

  // no own transmission means no collision next cycle
  a_col_tx_drop: assert property (@(posedge clk) disable iff (!reset_n) // R9
    ce && !tx_en_s |=> !col)
    else $error("collision without own transmit");

  // full duplex carrier only from the line
  a_crs_full_dup: assert property (@(posedge clk) disable iff (!reset_n) // R16
    ce && !half_duplex && !rx_carrier |=> !crs)
    else $error("full duplex carrier follows own transmit");

  // receive carrier always reaches the pin
  a_crs_rx_hold: assert property (@(posedge clk) disable iff (!reset_n) // R8
    ce && rx_carrier |=> crs)
    else $error("receive carrier not on crs");

  // carrier must not drop before the 13 bit minimum
  a_crs_off_min: assert property (@(posedge clk) disable iff (!reset_n) // R10
    (ce && speed_100 && rcar_ff == PMT_ACTIVE && rx_end) ##1 (ce && speed_100 && !rx_start)[*8]
      |-> rcar_ff == PMT_WAIT_OFF)
    else $error("receive carrier dropped early");

  // and must leave wait-off before the 18 bit maximum
  a_crs_off_max: assert property (@(posedge clk) disable iff (!reset_n) // R10
    (ce && speed_100 && rcar_ff == PMT_ACTIVE && rx_end) ##1 (ce && speed_100 && !rx_start)[*8]
      |-> ##[1:8] (rcar_ff != PMT_WAIT_OFF))
    else $error("receive carrier dropped late");

  // collision leads carrier by two cycles so it stays inside 9..13
  a_col_rx_on: assert property (@(posedge clk) disable iff (!reset_n) // R9
    (ce && speed_100 && half_duplex && tx_en_s && rcar_ff == PMT_IDLE && rx_start)
      ##1 (ce && speed_100 && half_duplex && tx_en_s)[*8] |=> col)
    else $error("collision not in 9 to 13 bit times");

  // collision ends together with the receive carrier
  a_col_off: assert property (@(posedge clk) disable iff (!reset_n) // R11
    ce && !rx_carrier && !col_pre |=> !col)
    else $error("collision lingers after receive end");

  // idle line gives no receive nibble
  a_rx_nib_idle: assert property (@(posedge clk) disable iff (!reset_n) // R1
    ce && !rx_act_s |=> !rx_nib.en)
    else $error("receive nibble without frame");

  // receive data one register behind the synchronised line data
  a_rx_nib_data: assert property (@(posedge clk) disable iff (!reset_n) // R7
    ce |=> rx_nib.data == $past(rx_dat_ff))
    else $error("receive nibble data delayed");

  // line goes quiet one cycle after enable drops
  a_line_tx_drop: assert property (@(posedge clk) disable iff (!reset_n) // R2
    ce && !tx_en_s |=> !line_tx.en)
    else $error("line transmit after enable drop");

  // line data one register behind the synchronised nibble
  a_line_tx_data: assert property (@(posedge clk) disable iff (!reset_n) // R3
    ce |=> line_tx.data == $past(tx_dat_ff))
    else $error("line transmit data delayed");

  // clock never flagged valid while the window still runs
  a_por_early: assert property (@(posedge clk) disable iff (!reset_n) // R12
    !tx_clk_valid && por_cnt_ff < POR_CYCLES - 1 |=> !tx_clk_valid)
    else $error("transmit clock valid inside window");

  // once valid, only reset clears it
  a_por_sticky: assert property (@(posedge clk) disable iff (!reset_n) // R12
    tx_clk_valid |=> tx_clk_valid)
    else $error("transmit clock valid dropped");

  // 5-bit counter never loaded past the off delay
  a_rcnt_bound: assert property (@(posedge clk) disable iff (!reset_n) // R10
    rcnt_ff <= DLY_W'(CRS_RX_OFF_CYC))
    else $error("carrier counter out of range");

  // wait-on count stays below the carrier-on delay
  a_wait_on_cnt: assert property (@(posedge clk) disable iff (!reset_n) // R8
    rcar_ff == PMT_WAIT_ON |-> rcnt_ff < DLY_W'(CRS_RX_ON_CYC))
    else $error("carrier-on counter out of range");

  // 10M: one wait cycle only, far inside 7 bit times
  a_crs_10m_rx: assert property (@(posedge clk) disable iff (!reset_n) // R14
    (ce && !speed_100 && rcar_ff == PMT_IDLE && rx_start) ##1 (ce && !speed_100)
      |=> rcar_ff == PMT_ACTIVE)
    else $error("10M receive carrier late");

  // own transmit holds carrier up in half duplex
  a_crs_own_hd: assert property (@(posedge clk) disable iff (!reset_n) // R4 R6
    ce && half_duplex && tx_en_s |=> crs)
    else $error("half duplex carrier missing during transmit");

  // clock enable low freezes the outputs
  a_ce_freeze: assert property (@(posedge clk) disable iff (!reset_n)
    !ce |=> $stable(crs) && $stable(col) && $stable(rx_nib) && $stable(line_tx))
    else $error("outputs moved with clock enable low");

  // window counter pauses with the clock enable
  a_ce_hold_por: assert property (@(posedge clk) disable iff (!reset_n) // R12
    !ce |=> $stable(por_cnt_ff))
    else $error("window counter moved with clock enable low");

  // a new frame in wait-off keeps carrier without a gap
  a_rcar_restart: assert property (@(posedge clk) disable iff (!reset_n) // R10
    ce && rcar_ff == PMT_WAIT_OFF && rx_start |=> rcar_ff == PMT_ACTIVE)
    else $error("carrier gap on back-to-back frames");

  // receive valid follows the synchronised line level
  a_rx_nib_en: assert property (@(posedge clk) disable iff (!reset_n) // R7
    ce |=> rx_nib.en == $past(rx_act_s))
    else $error("receive valid out of step");

  // line enable follows the synchronised transmit enable
  a_line_tx_en: assert property (@(posedge clk) disable iff (!reset_n) // R2 R3
    ce |=> line_tx.en == $past(tx_en_s))
    else $error("line enable out of step");

  // nothing on the line and no transmit: carrier drops
  a_crs_rx_idle: assert property (@(posedge clk) disable iff (!reset_n) // R10
    ce && rcar_ff == PMT_IDLE && !tx_en_s |=> !crs)
    else $error("carrier without cause");
endmodule : pmt_core
`default_nettype wire

// [dv/pmt_line_model.sv]
// line receive pair model: frames of len clocks on request
// assumes start is a one-cycle pulse driven after the clk edge
`timescale 1ns/1ps
`default_nettype none
module pmt_line_model (
  // timing and request
  input wire logic clk,
  input wire logic start,
  input wire logic [7:0] len,
  // line receive pair
  output logic line_rx_active,
  output logic [3:0] line_rx_data
);
  logic [7:0] left_ff;
  initial begin
    left_ff = 8'h00;
    line_rx_active = 1'b0;
    line_rx_data = 4'h5;
  end
  // one clk per nibble, so one bit time per ns step of ten
  always @(posedge clk) begin : step
    logic s;
    s = start;
    #2;
    if (s) left_ff = len;
    else if (left_ff != 8'h00) left_ff = left_ff - 8'h01;
    line_rx_active = (left_ff != 8'h00);
    // idle line keeps toggling so stale data never matches
    line_rx_data = line_rx_active ? left_ff[3:0] : ~line_rx_data;
  end
endmodule : pmt_line_model
`default_nettype wire

// [dv/phy_mii_latency_carrier_timing_tb.sv]
// self-checking bench for pmt_core; bench acts as mac, line model feeds receive pair
// assumes pmt_pkg, pmt_sync and pmt_core are compiled first
`timescale 1ns/1ps
`default_nettype none
module phy_mii_latency_carrier_timing_tb;
  import pmt_pkg::*;
  localparam int POR_SIM = 20;
  logic clk = 1'b0, link_clk = 1'b0, link_run = 1'b0, reset_n = 1'b0;
  logic ce = 1'b1;
  logic speed_100 = 1'b1, half_duplex = 1'b1, start = 1'b0;
  logic [7:0] len = 8'h10;
  logic [15:0] lfsr_ff = 16'h0019;
  pmt_nib_s tx_nib = '0;
  pmt_nib_s line_tx, rx_nib;
  logic line_rx_active, crs, col, tx_clk_valid;
  logic [3:0] line_rx_data;
  int num_errors = 0, samples_checked = 0, n1, n2, t0;
  always #5 clk = ~clk;
  // link clock only runs during transmit frames
  // offset keeps link edges off the clk edges
  initial begin
    #3;
    forever #15 link_clk = link_run ? ~link_clk : 1'b0;
  end
  pmt_core #(.POR_CYCLES(POR_SIM)) uut (.clk(clk), .reset_n(reset_n), .ce(ce), .speed_100(speed_100),
    .half_duplex(half_duplex), .link_clk(link_clk), .tx_nib(tx_nib), .line_rx_active(line_rx_active),
    .line_rx_data(line_rx_data), .line_tx(line_tx), .rx_nib(rx_nib), .crs(crs), .col(col),
    .tx_clk_valid(tx_clk_valid));
  pmt_line_model line_model (.clk(clk), .start(start), .len(len), .line_rx_active(line_rx_active),
    .line_rx_data(line_rx_data));
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next
  function automatic logic sig(input int w);
    case (w)
      0: return crs;
      1: return col;
      2: return rx_nib.en;
      3: return line_tx.en;
      default: return tx_clk_valid;
    endcase
  endfunction : sig
  task automatic meas(input int w, input logic lvl, input int lim, output int n);
    n = 0;
    while (sig(w) !== lvl && n < lim) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask : meas
  task automatic chk_rng(input int n, input int lo, input int hi);
    samples_checked++;
    if (n < lo || n > hi) begin
      num_errors++;
      $display("[FAIL] t=%0t got %0h want %0h..%0h", $time, n, lo, hi);
    end
  endtask : chk_rng
  task automatic chk_val(input logic [3:0] got, input logic [3:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got %0h want %0h", $time, got, exp);
    end
  endtask : chk_val
  task automatic send_tx(input int cnt, input logic [3:0] d);
    link_run = 1'b1;
    repeat (cnt) begin
      @(posedge link_clk);
      #1;
      tx_nib = '{en: 1'b1, data: d};
    end
    @(posedge link_clk);
    #1;
    tx_nib.en = 1'b0;
    repeat (4) @(posedge link_clk);
    link_run = 1'b0;
  endtask : send_tx
  task automatic rx_frame(input logic [7:0] l);
    @(posedge clk);
    #1;
    len = l;
    start = 1'b1;
    @(posedge clk);
    #1;
    start = 1'b0;
  endtask : rx_frame
  function automatic int bt(input logic s);
    return s ? BIT_NS_100M / CLK_PERIOD_NS : BIT_NS_10M / CLK_PERIOD_NS;
  endfunction : bt
  task automatic tx_case(input logic s, input logic hd);
    logic [3:0] d;
    speed_100 = s;
    half_duplex = hd;
    d = lfsr_ff[3:0];
    lfsr_ff = lfsr_next(lfsr_ff);
    fork
      send_tx(20, d);
    join_none
    @(posedge tx_nib.en);
    @(posedge link_clk);
    fork
      meas(0, 1'b1, 30, n1);
      meas(3, 1'b1, 80, n2);
    join
    if (hd) chk_rng(n1, 0, (s ? CRS_TX_ON_100M_BT : CRS_TX_ON_10M_BT) * bt(s) + 4);
    else chk_rng(n1, 30, 30);
    chk_rng(n2, 0, (s ? TX_LAT_100M_BT : TX_LAT_10M_BT) * bt(s) + 4);
    chk_val(line_tx.data, d);
    if (hd) begin
      @(negedge tx_nib.en);
      meas(0, 1'b0, 80, n1);
      chk_rng(n1, 0, CRS_TX_OFF_BT * bt(s) + 4);
    end
    wait (link_run == 1'b0);
  endtask : tx_case
  // carrier, or collision when coll is set, measured from the line frame start; two sync clocks allowed on top
  task automatic rx_case(input logic s, input logic [7:0] l, input logic coll);
    speed_100 = s;
    half_duplex = 1'b1;
    if (coll) begin
      fork
        send_tx(50, 4'hA);
      join_none
      @(posedge tx_nib.en);
      repeat (6) @(posedge clk);
    end
    rx_frame(l);
    fork
      meas(coll, 1'b1, 200, n1);
      begin
        meas(2, 1'b1, 200, n2);
        chk_val(rx_nib.data, l[3:0]);
      end
    join
    chk_rng(n2, 0, (s ? RX_LAT_100M_BT : RX_LAT_10M_BT) * bt(s) + 2);
    if (s && coll) chk_rng(n1, COL_ON_MIN_BT - 1, COL_ON_MAX_BT + 2);
    if (s && !coll) chk_rng(n1, CRS_RX_ON_MIN_BT - 1, CRS_RX_ON_MAX_BT + 2);
    t0 = n1;
    meas(coll, 1'b0, 300, n1);
    if (s) chk_rng(t0 + n1, l + CRS_RX_OFF_MIN_BT - 1, l + CRS_RX_OFF_MAX_BT + 2);
    wait (link_run == 1'b0);
  endtask : rx_case
  task automatic wrap_up();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : wrap_up
  initial begin
    #200000;
    num_errors++;
    wrap_up();
  end
  initial begin
    repeat (16) @(posedge clk);
    #1;
    reset_n = 1'b1;
    ce = 1'b0;
    repeat (5) @(posedge clk);
    #1;
    ce = 1'b1;
    meas(4, 1'b1, 60, n1);
    chk_rng(n1 + 5, POR_SIM + 4, POR_SIM + 8);
    chk_rng(MDC_PERIOD_MIN_NS, 2 * MDC_HALF_MIN_NS, MDC_PERIOD_MIN_NS);
    tx_case(1'b1, 1'b1);
    tx_case(1'b0, 1'b1);
    tx_case(1'b1, 1'b0);
    rx_case(1'b1, 8'h10, 1'b1);
    for (int i = 0; i < 4; i++) begin
      rx_case(1'b1, 8'h14 + {2'b00, lfsr_ff[5:0]}, 1'b0);
      lfsr_ff = lfsr_next(lfsr_ff);
    end
    rx_case(1'b0, 8'h60, 1'b0);
    half_duplex = 1'b0;
    fork
      send_tx(20, 4'h3);
    join_none
    rx_frame(8'h08);
    meas(1, 1'b1, 40, n1);
    chk_rng(n1, 40, 40);
    wait (link_run == 1'b0);
    wrap_up();
  end
endmodule : phy_mii_latency_carrier_timing_tb
`default_nettype wire
